// >>> rtl/fsp_pkg.sv
// Shared constants and types for the flash self-programming pair
package fsp_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS      = 50;
  localparam int REL_MAX_NS  = 10000;
  localparam int REL_EXTRA   = 2;
  localparam int REL_CYC     = REL_MAX_NS / CLK_NS + REL_EXTRA;
  localparam int SETTLE_NS   = 8000;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC   = 4;
  localparam logic [7:0] REL_CNT    = 8'(REL_CYC);
  localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYC);
  localparam logic [7:0] WRITE_CNT  = 8'(WRITE_CYC - 1);
  // ----------------------------------------
  // Device register indexes
  // ----------------------------------------
  localparam logic [3:0] R_MODE  = 4'h0;
  localparam logic [3:0] R_PROT  = 4'h1;
  localparam logic [3:0] R_STAT  = 4'h2;
  localparam logic [3:0] R_CMD   = 4'h3;
  localparam logic [3:0] R_PTRH  = 4'h4;
  localparam logic [3:0] R_PTRL  = 4'h5;
  localparam logic [3:0] R_CMPH  = 4'h6;
  localparam logic [3:0] R_CMPL  = 4'h7;
  localparam logic [3:0] R_DATA  = 4'h8;
  localparam logic [3:0] R_SEC   = 4'h9;
  // Values and fields
  localparam logic [7:0] PROT_KEY  = 8'hA5;
  localparam logic [7:0] MODE_SP   = 8'h01;
  localparam logic [7:0] MODE_NORM = 8'h00;
  localparam logic [7:0] ERASED    = 8'hFF;
  localparam logic [7:0] ZERO8     = 8'h00;
  localparam logic [7:0] CMD_NONE  = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_BLANK = 8'h04;
  localparam int ST_SEQ = 0;
  localparam int ST_PROT = 1;
  localparam int ST_BLANK = 2;
  localparam int ST_RANGE = 3;
  localparam int ST_REFUSE = 4;
  localparam logic INS_NOP  = 1'h0;
  localparam logic INS_HALT = 1'h1;
  // ----------------------------------------
  // Controller software registers
  // ----------------------------------------
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_CMD    = 4'h1;
  localparam logic [3:0] H_BLK    = 4'h2;
  localparam logic [3:0] H_ADDR   = 4'h3;
  localparam logic [3:0] H_DATA   = 4'h4;
  localparam logic [3:0] H_RESULT = 4'h5;
  localparam logic [3:0] H_IRQ_ST = 4'h6;
  localparam logic [3:0] H_IRQ_CL = 4'h7;
  localparam logic [3:0] H_IRQ_EN = 4'h8;
  localparam int C_ENTER = 0;
  localparam int C_RUN = 1;
  localparam int C_EXIT = 2;
  localparam int C_EXT = 3;
  localparam int I_DONE = 0;
  localparam int I_ERR = 1;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0, SEQ_KEY = 2'h1, SEQ_VAL = 2'h3, SEQ_INV = 2'h2
  } fsp_seq_t;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0, ENG_WRITE = 2'h1, ENG_ERASE = 2'h3, ENG_BLANK = 2'h2
  } fsp_eng_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h0, HS_WR = 4'h1, HS_NOP = 4'h3, HS_HALT = 4'h2,
    HS_WREL = 4'h6, HS_SETL = 4'h7, HS_WCMD = 4'h5, HS_RDST = 4'h4,
    HS_CAP = 4'hC
  } fsp_hst_t;
  typedef enum logic [1:0] {OP_ENTER = 2'h0, OP_CMD = 2'h1, OP_EXIT = 2'h3} fsp_op_t;
endpackage

// >>> rtl/fsp_if.sv
// Link between the CPU-side controller and the flash control device
`timescale 1ns/1ps
interface fsp_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       instr_strb;
  logic       instr_code;
  logic       cpu_halted;
  logic       cpu_stall;
  logic       irq_to_cpu;
  modport dev (
    input  clk, rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, instr_strb, instr_code,
    output reg_rdata, cpu_halted, cpu_stall, irq_to_cpu
  );
  modport cpu (
    input  clk, rst_n, reg_rdata, cpu_halted, cpu_stall, irq_to_cpu,
    output reg_addr, reg_wdata, reg_wr, reg_rd, instr_strb, instr_code
  );
endinterface

// >>> rtl/fsp_dev.sv
// Flash self-programming mode control, device end
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module fsp_dev
  import fsp_pkg::*;
(
  fsp_if.dev        bus,
  input  wire logic periph_irq,
  input  wire logic [7:0] pin_drive,
  output logic      [7:0] pin_q,
  input  wire logic prot_wr_dis,
  input  wire logic prot_er_dis,
  input  wire logic sec_wr_dis,
  input  wire logic sec_er_dis,
  output logic      sp_mode
);
  fsp_seq_t   seq_r;
  fsp_eng_t   eng_r;
  logic [7:0] seq_val_r;
  logic       mode_r;
  logic       armed_r;
  logic       nop_seen_r;
  logic       halted_r;
  logic       auto_r;
  logic       ready_r;
  logic [7:0] rel_cnt_r;
  logic [7:0] idx_r;
  logic [4:0] stat_r;
  logic [7:0] cmd_r;
  logic [7:0] ptrh_r;
  logic [7:0] ptrl_r;
  logic [7:0] cmph_r;
  logic [7:0] cmpl_r;
  logic [7:0] data_r;
  logic [7:0] rdata_r;
  logic [7:0] pin_r;
  logic [7:0] mem [0:4095];

  logic       wr_acc;
  logic       wr_mode;
  logic       commit;
  logic       seq_fail;
  logic       cmd_start;
  logic       ok_ctx;
  logic       known;
  logic       range_bad;
  logic       prot_bad;
  logic       launch;
  logic       blank_fail;
  logic [4:0] ev;
  logic [11:0] ptr_a;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Writes are refused while a command runs
  assign wr_acc  = bus.reg_wr & (eng_r == ENG_IDLE);
  assign wr_mode = wr_acc & (bus.reg_addr == R_MODE);
  assign commit  = wr_mode & (seq_r == SEQ_INV) & (bus.reg_wdata == seq_val_r);
  // Any write breaking the protected sequence
  assign seq_fail = wr_acc & (
      (wr_mode & ((seq_r == SEQ_IDLE)
        | ((seq_r == SEQ_VAL) & (bus.reg_wdata != ~seq_val_r))
        | ((seq_r == SEQ_INV) & (bus.reg_wdata != seq_val_r))))
    | ((bus.reg_addr == R_PROT) & (bus.reg_wdata != PROT_KEY))
    | (!wr_mode & (bus.reg_addr != R_PROT) & (seq_r != SEQ_IDLE)));

  // ----------------------------------------
  // Protected mode sequence
  // ----------------------------------------
  // Key, value, inverted value, value again
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      seq_r     <= SEQ_IDLE;
      seq_val_r <= ZERO8;
      mode_r    <= 1'b0;
    end else if (wr_acc) begin
      if (seq_fail) begin
        seq_r <= SEQ_IDLE;
      end else if (bus.reg_addr == R_PROT) begin
        seq_r <= SEQ_KEY;
      end else begin
        case (seq_r)
          SEQ_KEY: begin
            seq_val_r <= bus.reg_wdata;
            seq_r     <= SEQ_VAL;
          end
          SEQ_VAL: seq_r <= SEQ_INV;
          SEQ_INV: begin
            mode_r <= bus.reg_wdata[0];
            seq_r  <= SEQ_IDLE;
          end
          default: seq_r <= SEQ_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // NOP/HALT handshake and release
  // ----------------------------------------
  // HALT after entry plus NOP runs a timed release
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      armed_r    <= 1'b0;
      nop_seen_r <= 1'b0;
      halted_r   <= 1'b0;
      auto_r     <= 1'b0;
      ready_r    <= 1'b0;
      rel_cnt_r  <= 8'h00;
    end else begin
      if (commit) begin
        armed_r    <= bus.reg_wdata[0];
        nop_seen_r <= 1'b0;
        ready_r    <= 1'b0;
      end else if (bus.instr_strb && !halted_r) begin
        if (bus.instr_code == INS_NOP) begin
          nop_seen_r <= armed_r;
        end else begin
          halted_r  <= 1'b1;
          auto_r    <= armed_r & nop_seen_r;
          armed_r   <= 1'b0;
          rel_cnt_r <= REL_CNT;
        end
      end else if (halted_r) begin
        if (auto_r) begin
          rel_cnt_r <= rel_cnt_r - 8'h01;
          if (rel_cnt_r == 8'h01) begin
            halted_r <= 1'b0;
            auto_r   <= 1'b0;
            ready_r  <= 1'b1;
          end
        end else if (periph_irq) begin
          halted_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Command checks
  // ----------------------------------------
  assign cmd_start = wr_acc & (bus.reg_addr == R_CMD) & (bus.reg_wdata != CMD_NONE);
  assign ok_ctx    = mode_r & ready_r & !halted_r;
  assign known     = (bus.reg_wdata == CMD_WRITE) | (bus.reg_wdata == CMD_ERASE)
                   | (bus.reg_wdata == CMD_BLANK);
  assign range_bad = (|ptrh_r[7:5]) | (|cmph_r[7:5]);
  // Security inputs take no part here, only the two protect inputs
  assign prot_bad  = ((bus.reg_wdata == CMD_WRITE) & prot_wr_dis)
                   | ((bus.reg_wdata == CMD_ERASE) & prot_er_dis);
  assign launch    = cmd_start & ok_ctx & known & !range_bad & !prot_bad;
  assign ptr_a     = {ptrh_r[3:0], ptrl_r};
  assign blank_fail = (eng_r == ENG_BLANK) & (mem[{ptrh_r[3:0], idx_r}] != ERASED);
  assign ev[ST_SEQ]    = seq_fail;
  assign ev[ST_PROT]   = cmd_start & ok_ctx & known & !range_bad & prot_bad;
  assign ev[ST_BLANK]  = blank_fail;
  assign ev[ST_RANGE]  = cmd_start & ok_ctx & range_bad;
  assign ev[ST_REFUSE] = cmd_start & (!ok_ctx | !known);

  // ----------------------------------------
  // Flash engine
  // ----------------------------------------
  // One command at a time, CPU held meanwhile
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      eng_r <= ENG_IDLE;
      idx_r <= 8'h00;
    end else begin
      case (eng_r)
        ENG_IDLE: begin
          if (launch) begin
            if (bus.reg_wdata == CMD_WRITE) begin
              eng_r <= ENG_WRITE;
              idx_r <= WRITE_CNT;
            end else if (bus.reg_wdata == CMD_ERASE) begin
              eng_r <= ENG_ERASE;
              idx_r <= 8'h00;
            end else begin
              eng_r <= ENG_BLANK;
              idx_r <= ptrl_r;
            end
          end
        end
        ENG_WRITE: begin
          idx_r <= idx_r - 8'h01;
          if (idx_r == 8'h00) eng_r <= ENG_IDLE;
        end
        ENG_ERASE: begin
          idx_r <= idx_r + 8'h01;
          if (idx_r == 8'hFF) eng_r <= ENG_IDLE;
        end
        ENG_BLANK: begin
          idx_r <= idx_r + 8'h01;
          if (idx_r == cmpl_r || idx_r == 8'hFF || blank_fail) eng_r <= ENG_IDLE;
        end
        default: eng_r <= ENG_IDLE;
      endcase
    end
  end
  assign bus.cpu_stall = (eng_r != ENG_IDLE);

  // Flash array, byte write and block fill
  always_ff @(posedge bus.clk) begin
    if (launch && bus.reg_wdata == CMD_WRITE) mem[ptr_a] <= data_r;
    if (eng_r == ENG_ERASE) mem[{ptrh_r[3:0], idx_r}] <= ERASED;
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Pointer, compare, data and command registers
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      cmd_r  <= CMD_NONE;
      ptrh_r <= ZERO8;
      ptrl_r <= ZERO8;
      cmph_r <= ZERO8;
      cmpl_r <= ZERO8;
      data_r <= ZERO8;
    end else if (wr_acc) begin
      case (bus.reg_addr)
        R_CMD:   cmd_r  <= bus.reg_wdata;
        R_PTRH:  ptrh_r <= bus.reg_wdata;
        R_PTRL:  ptrl_r <= bus.reg_wdata;
        R_CMPH:  cmph_r <= bus.reg_wdata;
        R_CMPL:  cmpl_r <= bus.reg_wdata;
        R_DATA:  data_r <= bus.reg_wdata;
        default: cmd_r  <= cmd_r;
      endcase
    end
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      stat_r <= 5'h00;
    end else if (wr_acc && bus.reg_addr == R_STAT) begin
      stat_r <= (stat_r & ~bus.reg_wdata[4:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  // Read data stands the cycle after the strobe only
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      rdata_r <= ZERO8;
    end else if (!bus.reg_rd) begin
      rdata_r <= ZERO8;
    end else begin
      case (bus.reg_addr)
        R_MODE:  rdata_r <= {7'h00, mode_r};
        R_STAT:  rdata_r <= {1'b0, ready_r, mode_r, stat_r};
        R_CMD:   rdata_r <= cmd_r;
        R_PTRH:  rdata_r <= ptrh_r;
        R_PTRL:  rdata_r <= ptrl_r;
        R_CMPH:  rdata_r <= cmph_r;
        R_CMPL:  rdata_r <= cmpl_r;
        R_DATA:  rdata_r <= mem[ptr_a];
        R_SEC:   rdata_r <= {6'h00, sec_er_dis, sec_wr_dis};
        default: rdata_r <= ZERO8;
      endcase
    end
  end
  assign bus.reg_rdata = rdata_r;

  // ----------------------------------------
  // Pins and interrupts
  // ----------------------------------------
  // Outputs hold while halted or in the mode
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      pin_r <= ZERO8;
    end else if (!halted_r && !mode_r) begin
      pin_r <= pin_drive;
    end
  end
  assign pin_q          = pin_r;
  assign sp_mode        = mode_r;
  assign bus.cpu_halted = halted_r;
  assign bus.irq_to_cpu = periph_irq & !mode_r;
endmodule

// >>> rtl/fsp_cpu.sv
// Flash self-programming controller, CPU end
`timescale 1ns/1ps
module fsp_cpu
  import fsp_pkg::*;
(
  fsp_if.cpu        bus,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic sw_wr,
  input  wire logic sw_rd,
  output logic      [7:0] sw_rdata,
  output logic      irq,
  output logic      cpu_irq_take
);
  fsp_hst_t   st_r, st_nxt;
  fsp_op_t    op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic [7:0] cnt_r;
  logic       last_r;
  logic       seen_r;
  logic       ext_r;
  logic [7:0] code_r;
  logic [7:0] blk_r;
  logic [7:0] addr_r;
  logic [7:0] wd_r;
  logic [7:0] res_r;
  logic [1:0] ist_r;
  logic [1:0] ien_r;
  logic [7:0] mask0_r;
  logic       dis_r;
  logic [7:0] rd_r;
  logic [3:0] ba_r;
  logic [7:0] bd_r;
  logic       bw_r;
  logic       br_r;
  logic       bi_r;
  logic       bc_r;
  logic [3:0] w_a;
  logic [7:0] w_d;
  logic       w_last;
  logic       go;
  logic [1:0] iev;

  // ----------------------------------------
  // Write lists for each operation
  // ----------------------------------------
  always_comb begin
    w_a = R_CMD;
    w_d = CMD_NONE;
    w_last = 1'b0;
    if (op_nxt == OP_CMD) begin
      case (step_nxt)
        3'h0: begin w_a = R_PTRH; w_d = {4'h0, blk_r[3:0]}; end
        3'h1: begin w_a = R_CMPH; w_d = {4'h0, blk_r[3:0]}; end
        3'h2: begin w_a = R_PTRL; w_d = addr_r; end
        3'h3: begin
          w_a = R_CMPL;
          w_d = (code_r == CMD_ERASE) ? ZERO8 : (code_r == CMD_BLANK) ? ERASED : addr_r;
        end
        3'h4: begin w_a = R_DATA; w_d = wd_r; end
        default: begin w_a = R_CMD; w_d = code_r; w_last = 1'b1; end
      endcase
    end else begin
      case (step_nxt)
        3'h0: begin w_a = R_CMD; w_d = CMD_NONE; end
        3'h1: begin w_a = R_PROT; w_d = PROT_KEY; end
        3'h3: begin w_a = R_MODE; w_d = (op_nxt == OP_ENTER) ? ~MODE_SP : ~MODE_NORM; end
        default: begin
          w_a = R_MODE;
          w_d = (op_nxt == OP_ENTER) ? MODE_SP : MODE_NORM;
          w_last = (step_nxt == 3'h4);
        end
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign go = sw_wr & (sw_addr == H_CTRL) & (st_r == HS_IDLE);
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    case (st_r)
      HS_IDLE: begin
        step_nxt = 3'h0;
        if (go && sw_wdata[C_ENTER]) begin op_nxt = OP_ENTER; st_nxt = HS_WR; end
        else if (go && sw_wdata[C_RUN]) begin op_nxt = OP_CMD; st_nxt = HS_WR; end
        else if (go && sw_wdata[C_EXIT]) begin op_nxt = OP_EXIT; st_nxt = HS_WR; end
      end
      HS_WR: begin
        // Leave only once the last write stands on the link
        if (last_r) begin
          st_nxt = (op_r == OP_ENTER) ? HS_NOP : (op_r == OP_CMD) ? HS_WCMD : HS_IDLE;
        end else begin
          step_nxt = step_r + 3'h1;
        end
      end
      HS_NOP:  st_nxt = HS_HALT;
      HS_HALT: st_nxt = HS_WREL;
      HS_WREL: if (seen_r && !bus.cpu_halted) st_nxt = ext_r ? HS_SETL : HS_IDLE;
      HS_SETL: if (cnt_r == 8'h01) st_nxt = HS_IDLE;
      HS_WCMD: if (!bus.cpu_stall) st_nxt = HS_RDST;
      HS_RDST: st_nxt = HS_CAP;
      HS_CAP:  st_nxt = HS_IDLE;
      default: st_nxt = HS_IDLE;
    endcase
  end
  // List looked up at the step driven; last_r marks the final write on the link
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      st_r   <= HS_IDLE;
      op_r   <= OP_ENTER;
      step_r <= 3'h0;
      last_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      step_r <= (st_r == HS_WR && w_last) ? 3'h0 : step_nxt;
      last_r <= (st_r == HS_WR) & w_last;
    end
  end

  // Registered bus drive, aligned with the state
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      ba_r <= 4'h0;
      bd_r <= ZERO8;
      bw_r <= 1'b0;
      br_r <= 1'b0;
      bi_r <= 1'b0;
      bc_r <= INS_NOP;
    end else begin
      ba_r <= (st_nxt == HS_RDST) ? R_STAT : w_a;
      bd_r <= w_d;
      bw_r <= (st_nxt == HS_WR);
      br_r <= (st_nxt == HS_RDST);
      bi_r <= (st_nxt == HS_NOP) | (st_nxt == HS_HALT);
      bc_r <= (st_nxt == HS_HALT) ? INS_HALT : INS_NOP;
    end
  end
  assign bus.reg_addr   = ba_r;
  assign bus.reg_wdata  = bd_r;
  assign bus.reg_wr     = bw_r;
  assign bus.reg_rd     = br_r;
  assign bus.instr_strb = bi_r;
  assign bus.instr_code = bc_r;

  // Release watch and settling count, sized for a 20 MHz clock
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      seen_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else begin
      seen_r <= (st_r == HS_WREL) & (seen_r | bus.cpu_halted);
      cnt_r  <= (st_r == HS_SETL) ? cnt_r - 8'h01 : SETTLE_CNT;
    end
  end

  // Interrupts masked from entry until exit completes
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      mask0_r <= ZERO8;
      dis_r   <= 1'b0;
    end else if (go && sw_wdata[C_ENTER]) begin
      mask0_r <= MASK_ALL;
      dis_r   <= 1'b1;
    end else if (st_r == HS_WR && op_r == OP_EXIT && last_r) begin
      mask0_r <= ZERO8;
      dis_r   <= 1'b0;
    end
  end
  assign cpu_irq_take = bus.irq_to_cpu & !dis_r & !mask0_r[0];

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      ext_r  <= 1'b0;
      code_r <= CMD_NONE;
      blk_r  <= ZERO8;
      addr_r <= ZERO8;
      wd_r   <= ZERO8;
      ien_r  <= 2'h0;
    end else if (sw_wr) begin
      case (sw_addr)
        H_CTRL:   ext_r  <= sw_wdata[C_EXT];
        H_CMD:    code_r <= sw_wdata;
        H_BLK:    blk_r  <= sw_wdata;
        H_ADDR:   addr_r <= sw_wdata;
        H_DATA:   wd_r   <= sw_wdata;
        H_IRQ_EN: ien_r  <= sw_wdata[1:0];
        default:  ien_r  <= ien_r;
      endcase
    end
  end

  // Result capture, each error flag tested on its own bit
  assign iev[I_DONE] = (st_r != HS_IDLE) & (st_nxt == HS_IDLE);
  assign iev[I_ERR]  = (st_r == HS_CAP) & (bus.reg_rdata[ST_SEQ] | bus.reg_rdata[ST_PROT]
                     | bus.reg_rdata[ST_BLANK] | bus.reg_rdata[ST_RANGE]
                     | bus.reg_rdata[ST_REFUSE]);
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      res_r <= ZERO8;
      ist_r <= 2'h0;
    end else begin
      if (st_r == HS_CAP) res_r <= bus.reg_rdata;
      ist_r <= (ist_r & ~((sw_wr && sw_addr == H_IRQ_CL) ? sw_wdata[1:0] : 2'h0)) | iev;
    end
  end
  assign irq = |(ist_r & ien_r);

  // Read port, data the cycle after the strobe only
  always_ff @(posedge bus.clk or negedge bus.rst_n) begin
    if (!bus.rst_n) begin
      rd_r <= ZERO8;
    end else if (!sw_rd) begin
      rd_r <= ZERO8;
    end else begin
      case (sw_addr)
        H_CTRL:   rd_r <= {(st_r != HS_IDLE), dis_r, 2'h0, ext_r, 3'h0};
        H_CMD:    rd_r <= code_r;
        H_BLK:    rd_r <= blk_r;
        H_ADDR:   rd_r <= addr_r;
        H_DATA:   rd_r <= wd_r;
        H_RESULT: rd_r <= res_r;
        H_IRQ_ST: rd_r <= {6'h00, ist_r};
        H_IRQ_EN: rd_r <= {6'h00, ien_r};
        default:  rd_r <= ZERO8;
      endcase
    end
  end
  assign sw_rdata = rd_r;
endmodule

// >>> tb/fsp_assertions.sv
// Assertions on the link between controller and device
`timescale 1ns/1ps
module fsp_assertions
  import fsp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       instr_strb,
  input wire logic       instr_code,
  input wire logic       cpu_halted,
  input wire logic       cpu_stall,
  input wire logic       irq_to_cpu
);
  int hc_r;
  int sc_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Halt length and time since release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hc_r <= 0;
      sc_r <= 0;
    end else begin
      hc_r <= cpu_halted ? hc_r + 1 : 0;
      sc_r <= cpu_halted ? 0 : (sc_r < SETTLE_CYC ? sc_r + 1 : sc_r);
    end
  end
  // Entry writes, then the instruction pair
  sequence s_mode_on;
    reg_wr && reg_addr == R_MODE && reg_wdata == ~MODE_SP
    ##1 reg_wr && reg_addr == R_MODE && reg_wdata == MODE_SP;
  endsequence
  sequence s_nop_halt;
    instr_strb && instr_code == INS_NOP ##1 instr_strb && instr_code == INS_HALT;
  endsequence
  nop_halt_a: assert property (s_mode_on |=> s_nop_halt ##1 cpu_halted)
    else $error("entry not followed by nop and halt");
  halt_len_a: assert property (cpu_halted |-> hc_r <= REL_CYC)
    else $error("halt held too long");
  cmd_settle_a: assert property (
    reg_wr && reg_addr == R_CMD && reg_wdata != CMD_NONE |-> sc_r >= SETTLE_CYC)
    else $error("command before settle time");
  ptr_high_a: assert property (
    reg_wr && (reg_addr == R_PTRH || reg_addr == R_CMPH) |-> reg_wdata[7:4] == 4'h0)
    else $error("pointer high bits set");
  cmd_clear_a: assert property (reg_wr && reg_addr == R_PROT |-> $past(reg_wr) &&
    $past(reg_addr) == R_CMD && $past(reg_wdata) == CMD_NONE)
    else $error("command register not cleared");
  stall_irq_a: assert property (cpu_stall |-> !irq_to_cpu)
    else $error("interrupt passed during command");
  stall_quiet_a: assert property (cpu_stall |-> !(reg_wr || reg_rd || instr_strb))
    else $error("cpu active while stalled");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

// >>> tb/tb_flash_self_program_mode_control.sv
// Self-checking bench for the self-programming pair
`timescale 1ns/1ps
module tb_flash_self_program_mode_control
  import fsp_pkg::*;
;
  logic       clk = 0;
  logic       rst_n = 0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic       sw_wr = 0;
  logic       sw_rd = 0;
  logic [7:0] sw_rdata;
  logic       irq;
  logic       take;
  logic       periph_irq = 0;
  logic [7:0] pin_drive = 8'h5A;
  logic [7:0] pin_q;
  logic [1:0] prot = 0;
  logic [1:0] sec = 0;
  logic       sp_mode;
  logic [7:0] st;
  logic [7:0] cmds [6] = '{CMD_ERASE, CMD_BLANK, CMD_WRITE, CMD_BLANK, CMD_WRITE, CMD_ERASE};
  int         num_errors = 0;
  int         num_checks = 0;
  always #25 clk = ~clk;
  // Both ends joined by the link, checker beside it
  fsp_if bus (.clk(clk), .rst_n(rst_n));
  fsp_dev u_fsp_dev (.bus(bus), .periph_irq(periph_irq), .pin_drive(pin_drive),
    .pin_q(pin_q), .prot_wr_dis(prot[1]), .prot_er_dis(prot[0]), .sec_wr_dis(sec[1]),
    .sec_er_dis(sec[0]), .sp_mode(sp_mode));
  fsp_cpu u_fsp_cpu (.bus(bus), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .cpu_irq_take(take));
  fsp_assertions u_fsp_assertions (.clk(clk), .rst_n(rst_n), .reg_addr(bus.reg_addr),
    .reg_wdata(bus.reg_wdata), .reg_wr(bus.reg_wr), .reg_rd(bus.reg_rd),
    .reg_rdata(bus.reg_rdata), .instr_strb(bus.instr_strb), .instr_code(bus.instr_code),
    .cpu_halted(bus.cpu_halted), .cpu_stall(bus.cpu_stall), .irq_to_cpu(bus.irq_to_cpu));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Software port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    @(negedge clk);
    st = sw_rdata;
  endtask
  // Clear status, start, wait for the interrupt, judge status
  task automatic go(input logic [7:0] v, input logic [7:0] exp);
    wr(H_IRQ_CL, 8'h03);
    wr(H_CTRL, v);
    for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(negedge clk);
    rd(H_IRQ_ST);
    chk(st, exp);
  endtask
  task automatic t_enter;
    wr(H_IRQ_EN, 8'h03);
    go(8'h09, 8'h01);
    chk({7'h0, sp_mode}, 8'h01);
    @(posedge clk);
    pin_drive <= 8'hA5;
    periph_irq <= 1'b1;
    repeat (3) @(negedge clk);
    chk(pin_q, 8'h5A);
    chk({6'h0, bus.irq_to_cpu, take}, 8'h00);
    $display("test enter done");
  endtask
  // Erase, blank, write, failing blank, protected write and erase
  task automatic t_cmds;
    wr(H_BLK, 8'h01);
    wr(H_ADDR, 8'h05);
    wr(H_DATA, 8'h3C);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      prot <= {i == 4, i == 5};
      sec <= 2'b11;
      wr(H_CMD, cmds[i]);
      go(8'h0A, {6'h0, i > 2, 1'b1});
      rd(H_RESULT);
      chk(st, {3'h3, 2'h0, i > 2, i > 3, 1'b0});
    end
    $display("test commands done");
  endtask
  task automatic t_exit;
    go(8'h0C, 8'h01);
    repeat (3) @(negedge clk);
    chk({7'h0, sp_mode}, 8'h00);
    chk(pin_q, 8'hA5);
    chk({7'h0, bus.irq_to_cpu}, 8'h01);
    rd(4'hF);
    chk(st, 8'h00);
    wr(H_IRQ_EN, 8'h00);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    wr(H_IRQ_EN, 8'h03);
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    wr(H_IRQ_CL, 8'h03);
    @(negedge clk);
    chk({7'h0, irq}, 8'h00);
    $display("test exit done");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_enter;
    t_cmds;
    t_exit;
    summarize;
  end
  // Watchdog
  initial begin
    #2000000;
    num_errors++;
    summarize;
  end
endmodule
